// *** logic/exec_core.v ***
// Purpose: Two-stage fetch/execute core with 14-bit program bus and 8-bit data path.
// Assumes: Program and file memories answer combinationally within the cycle.
// Notes:   File writes are registered one cycle; a matching read is forwarded.
`timescale 1ns/1ps
`include "core_consts.vh"

module exec_core #(
  parameter STACK_DEPTH = 8,
  parameter SP_W        = 3
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Program memory
  output wire [11:0] prog_addr,
  input  wire [13:0] prog_data,
  // File register memory
  output reg  [6:0]  data_raddr,
  input  wire [7:0]  data_rdata,
  output reg  [6:0]  data_waddr,
  output reg  [7:0]  data_wdata,
  output reg         data_we,
  // Interrupt request
  input  wire        irq,
  // Observed state
  output reg  [7:0]  w_out,
  output reg  [7:0]  status_out
);

  // ============================================================
  // State
  reg  [12:0]     pc_r;
  reg  [13:0]     ir_r;
  reg             valid_r;
  reg  [7:0]      w_r;
  reg  [7:0]      fsr_r;
  reg  [4:0]      pclath_r;
  reg             gie_r;
  reg  [SP_W-1:0] sp_r;
  reg  [12:0]     stk_r [0:STACK_DEPTH-1];

  assign prog_addr = pc_r[11:0];

  // ============================================================
  // Operand fetch with internal register map and forwarding
  wire [6:0] ea     = data_raddr;
  wire       is_sfr = (ea == `ADR_INDF) || (ea == `ADR_PCL) || (ea == `ADR_STATUS) ||
                      (ea == `ADR_FSR) || (ea == `ADR_PCLATH) || (ea == `ADR_INTCON);
  reg  [7:0] fval;

  always @* begin
    case (ea)
      `ADR_PCL:    fval = pc_r[7:0];
      `ADR_STATUS: fval = status_out;
      `ADR_FSR:    fval = fsr_r;
      `ADR_PCLATH: fval = {3'b000, pclath_r};
      `ADR_INTCON: fval = {gie_r, 7'h00};
      `ADR_INDF:   fval = 8'h00;
      default:     fval = (data_we && data_waddr == ea) ? data_wdata : data_rdata;
    endcase
  end

  // ============================================================
  // Decode
  reg  [3:0]  alu_op;
  reg  [7:0]  alu_b;
  reg         wr_w, wr_f, upd_z, upd_c, upd_dc;
  reg         bit_op, skip, branch, push, pop, retfie, sleep_op, clrwdt_op;
  reg  [12:0] target;
  wire [7:0]  alu_res;
  wire        alu_c, alu_dc, alu_z;
  wire [7:0]  mask = 8'h01 << ir_r[9:7];
  wire [7:0]  bit_val = ir_r[10] ? (fval | mask) : (fval & ~mask);
  wire [7:0]  res = bit_op ? bit_val : alu_res;

  alu8 u_alu (
    .op              (alu_op),
    .carry_in        (status_out[`ST_C]),
    .a               (w_r),
    .b               (alu_b),
    .result          (alu_res),
    .carry_out       (alu_c),
    .digit_carry_out (alu_dc),
    .zero            (alu_z)
  );

  always @* begin
    alu_op = `ALU_PASS_B;
    alu_b = fval;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    bit_op = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    retfie = 1'b0;
    sleep_op = 1'b0;
    clrwdt_op = 1'b0;
    target = stk_r[sp_r - {{(SP_W-1){1'b0}}, 1'b1}];
    if (valid_r) begin
      case (ir_r[13:12])
        2'b00: begin
          alu_op = ir_r[11:8];
          if (ir_r[11:8] == `ALU_PASS_A) begin
            if (ir_r[7]) begin
              wr_f = 1'b1;
            end else begin
              case (ir_r[6:0])
                `OPW_RETURN: begin
                  pop = 1'b1;
                  branch = 1'b1;
                end
                `OPW_RETFIE: begin
                  pop = 1'b1;
                  branch = 1'b1;
                  retfie = 1'b1;
                end
                `OPW_SLEEP:  sleep_op = 1'b1;
                `OPW_CLRWDT: clrwdt_op = 1'b1;
                default: ;
              endcase
            end
          end else begin
            wr_f = ir_r[7];
            wr_w = ~ir_r[7];
            upd_z = (ir_r[11:8] <= `ALU_INC);
            upd_c = (ir_r[11:8] == `ALU_SUB) || (ir_r[11:8] == `ALU_ADD) ||
                    (ir_r[11:8] == `ALU_RR) || (ir_r[11:8] == `ALU_RL);
            upd_dc = (ir_r[11:8] == `ALU_SUB) || (ir_r[11:8] == `ALU_ADD);
            skip = ((ir_r[11:8] == `ALU_DECSZ) || (ir_r[11:8] == `ALU_INCSZ)) && alu_z;
          end
        end
        2'b01: begin
          bit_op = 1'b1;
          wr_f = ~ir_r[11];
          if (ir_r[11])
            skip = ir_r[10] ? (|(fval & mask)) : ~(|(fval & mask));
        end
        2'b10: begin
          branch = 1'b1;
          push = ~ir_r[11];
          target = {pclath_r[4:3], ir_r[10:0]};
        end
        default: begin
          alu_b = ir_r[7:0];
          wr_w = 1'b1;
          casez (ir_r[11:8])
            4'b00??: alu_op = `ALU_PASS_B;
            4'b01??: begin
              alu_op = `ALU_PASS_B;
              pop = 1'b1;
              branch = 1'b1;
            end
            4'b1000: alu_op = `ALU_IOR;
            4'b1001: alu_op = `ALU_AND;
            4'b1010: alu_op = `ALU_XOR;
            4'b110?: alu_op = `ALU_SUB;
            4'b111?: alu_op = `ALU_ADD;
            default: wr_w = 1'b0;
          endcase
          upd_z = ir_r[11] && (ir_r[11:8] != 4'b1011);
          upd_c = (ir_r[11:10] == 2'b11);
          upd_dc = (ir_r[11:10] == 2'b11);
        end
      endcase
      // Writing the low program counter byte is a computed jump
      if (wr_f && ea == `ADR_PCL) begin
        branch = 1'b1;
        target = {pclath_r, res};
      end
    end
  end

  // ============================================================
  // Next-state values of mapped registers
  wire        squash = branch || skip;
  wire        irq_take = irq && gie_r && !squash && !retfie;
  reg  [7:0]  status_nxt;
  reg  [7:0]  fsr_nxt;
  reg  [12:0] pc_nxt;
  reg  [6:0]  f_nxt;

  always @* begin
    status_nxt = status_out;
    fsr_nxt = fsr_r;
    if (wr_f && ea == `ADR_STATUS)
      status_nxt = {res[7:5], status_out[`ST_TO], status_out[`ST_PD], res[2:0]};
    if (wr_f && ea == `ADR_FSR)
      fsr_nxt = res;
    // Flag updates win over a direct write of the status register
    if (upd_z)
      status_nxt[`ST_Z] = alu_z;
    if (upd_c)
      status_nxt[`ST_C] = alu_c;
    if (upd_dc)
      status_nxt[`ST_DC] = alu_dc;
    if (sleep_op || clrwdt_op) begin
      status_nxt[`ST_TO] = 1'b1;
      status_nxt[`ST_PD] = clrwdt_op;
    end
    if (irq_take)
      pc_nxt = `IRQ_VECTOR;
    else if (branch)
      pc_nxt = target;
    else
      pc_nxt = pc_r + 13'h0001;
    // Indirect access resolves through the updated pointer
    f_nxt = (prog_data[6:0] == `ADR_INDF) ? fsr_nxt[6:0] : prog_data[6:0];
  end

  // ============================================================
  // Pipeline and register update
  always @(posedge clk) begin
    if (rst) begin
      pc_r <= `PC_RST;
      ir_r <= 14'h0000;
      valid_r <= 1'b0;
      w_r <= 8'h00;
      w_out <= 8'h00;
      fsr_r <= 8'h00;
      pclath_r <= 5'h00;
      gie_r <= 1'b0;
      sp_r <= {SP_W{1'b0}};
      status_out <= `STATUS_RST;
      data_raddr <= 7'h00;
      data_waddr <= 7'h00;
      data_wdata <= 8'h00;
      data_we <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      ir_r <= prog_data;
      valid_r <= !(squash || irq_take);
      data_raddr <= f_nxt;
      status_out <= status_nxt;
      fsr_r <= fsr_nxt;
      if (wr_w) begin
        w_r <= res;
        w_out <= res;
      end
      if (wr_f && ea == `ADR_PCLATH)
        pclath_r <= res[4:0];
      if (irq_take)
        gie_r <= 1'b0;
      else if (retfie)
        gie_r <= 1'b1;
      else if (wr_f && ea == `ADR_INTCON)
        gie_r <= res[`INTCON_GIE];
      data_we <= wr_f && !is_sfr;
      data_waddr <= ea;
      data_wdata <= res;
      // Stack wraps circularly; overflow overwrites the oldest entry
      if (push || irq_take) begin
        stk_r[sp_r] <= pc_r;
        sp_r <= sp_r + {{(SP_W-1){1'b0}}, 1'b1};
      end else if (pop) begin
        sp_r <= sp_r - {{(SP_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // exec_core

// *** include/core_consts.vh ***
// Purpose: Shared constants for the 8-bit execution core and its arithmetic unit.
// Assumes: 7-bit direct file addresses, single data bank.
// Notes:   Arithmetic codes match the byte-instruction operation nibble.
`ifndef CORE_CONSTS_VH
`define CORE_CONSTS_VH

// ============================================================
// Vectors and reset values
`define RESET_VECTOR    13'h0000
`define IRQ_VECTOR      13'h0004
`define STATUS_RST      8'h18
`define PC_RST          13'h0000

// ============================================================
// Mapped core register addresses
`define ADR_INDF        7'h00
`define ADR_PCL         7'h02
`define ADR_STATUS      7'h03
`define ADR_FSR         7'h04
`define ADR_PCLATH      7'h0A
`define ADR_INTCON      7'h0B

// ============================================================
// Status and control bit positions
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define ST_PD           3
`define ST_TO           4
`define INTCON_GIE      7

// ============================================================
// Arithmetic unit operation codes
`define ALU_PASS_A      4'h0
`define ALU_CLR         4'h1
`define ALU_SUB         4'h2
`define ALU_DEC         4'h3
`define ALU_IOR         4'h4
`define ALU_AND         4'h5
`define ALU_XOR         4'h6
`define ALU_ADD         4'h7
`define ALU_PASS_B      4'h8
`define ALU_COM         4'h9
`define ALU_INC         4'hA
`define ALU_DECSZ       4'hB
`define ALU_RR          4'hC
`define ALU_RL          4'hD
`define ALU_SWAP        4'hE
`define ALU_INCSZ       4'hF

// ============================================================
// Control instruction words (upper bits zero)
`define OPW_RETURN      7'h08
`define OPW_RETFIE      7'h09
`define OPW_SLEEP       7'h63
`define OPW_CLRWDT      7'h64

`endif

// *** logic/alu8.v ***
// Purpose: 8-bit arithmetic unit with carry, digit-carry and zero outputs.
// Assumes: a is the working accumulator, b the file register or literal.
// Notes:   Subtraction is b minus a; carry out high means no borrow.
`timescale 1ns/1ps
`include "core_consts.vh"

module alu8 (
  // Operation
  input  wire [3:0] op,
  input  wire       carry_in,
  // Operands
  input  wire [7:0] a,
  input  wire [7:0] b,
  // Results
  output reg  [7:0] result,
  output reg        carry_out,
  output reg        digit_carry_out,
  output wire       zero
);

  // ============================================================
  // Shared adder: subtraction is b + ~a + 1 in two's complement
  wire       is_sub = (op == `ALU_SUB);
  wire [7:0] addend = is_sub ? ~a : a;
  wire [8:0] sum    = {1'b0, b} + {1'b0, addend} + {8'h00, is_sub};
  wire [4:0] nib    = {1'b0, b[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};

  // ============================================================
  // Operation select
  always @* begin
    carry_out       = carry_in;
    digit_carry_out = nib[4];
    case (op)
      `ALU_PASS_A: result = a;
      `ALU_CLR:    result = 8'h00;
      `ALU_SUB,
      `ALU_ADD: begin
        result    = sum[7:0];
        carry_out = sum[8];
      end
      `ALU_DEC,
      `ALU_DECSZ:  result = b - 8'h01;
      `ALU_IOR:    result = a | b;
      `ALU_AND:    result = a & b;
      `ALU_XOR:    result = a ^ b;
      `ALU_PASS_B: result = b;
      `ALU_COM:    result = ~b;
      `ALU_INC,
      `ALU_INCSZ:  result = b + 8'h01;
      `ALU_RR: begin
        result    = {carry_in, b[7:1]};
        carry_out = b[0];
      end
      `ALU_RL: begin
        result    = {b[6:0], carry_in};
        carry_out = b[7];
      end
      `ALU_SWAP:   result = {b[3:0], b[7:4]};
      default:     result = b;
    endcase
  end

  assign zero = (result == 8'h00);

endmodule // alu8

// *** test/prog_file_model.sv ***
// Purpose: Program and file memories on the far side of the execution core.
// Assumes: Both memories answer combinationally within the cycle.
// Notes:   The bench loads the program array directly before reset ends.
`timescale 1ns/1ps

module prog_file_model (
  // Clock
  input  wire        clk,
  // Program memory
  input  wire [11:0] prog_addr,
  output wire [13:0] prog_data,
  // File memory
  input  wire [6:0]  data_raddr,
  output wire [7:0]  data_rdata,
  input  wire [6:0]  data_waddr,
  input  wire [7:0]  data_wdata,
  input  wire        data_we
);
  // ============================================================
  // Storage
  reg [13:0] rom [0:4095];
  reg [7:0]  ram [0:127];

  assign prog_data  = rom[prog_addr];
  assign data_rdata = ram[data_raddr];

  always @(posedge clk) begin
    if (data_we) begin
      ram[data_waddr] <= data_wdata;
    end
  end
endmodule // prog_file_model

// *** test/exec_core_monitor.sv ***
// Purpose: Port checker for the execution core.
// Assumes: PCLATH stays zero; fetch-order checks skip cycles with irq high.
// Notes:   Slots are judged only behind a NOP, so a squash never misleads.
`timescale 1ns/1ps

module exec_core_monitor #(
  parameter STACK_DEPTH = 8,
  parameter SP_W        = 3
) (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Program memory
  input wire [11:0] prog_addr,
  input wire [13:0] prog_data,
  // File memory
  input wire [6:0]  data_raddr,
  input wire [7:0]  data_rdata,
  input wire [6:0]  data_waddr,
  input wire [7:0]  data_wdata,
  input wire        data_we,
  // Interrupt and state
  input wire        irq,
  input wire [7:0]  w_out,
  input wire [7:0]  status_out
);
  default clocking cb @(posedge clk); endclocking

  // ============================================================
  // Reset and fetch order
  reset_state_a: assert property (rst |=> prog_addr == 12'h000 && status_out == 8'h18
    && w_out == 8'h00 && !data_we) else $error("reset state wrong");
  fetch_start_a: assert property ($fell(rst) |-> prog_addr == 12'h000
    ##1 prog_addr == 12'h001) else $error("fetch did not start at zero");
  nop_step_a: assert property (disable iff (rst) prog_data == 14'h0000 && !irq
    |=> ##1 prog_addr == $past(prog_addr) + 12'h001) else $error("no single step");
  wrap_around_a: assert property (disable iff (rst) $past(prog_data) == 14'h0000 && !irq
    && prog_addr == 12'hFFF |=> prog_addr == 12'h000) else $error("no wrap");

  // ============================================================
  // Branches
  sequence goto_run_s;
    $past(prog_data) == 14'h0000 && prog_data[13:11] == 3'b101 && !irq;
  endsequence
  goto_target_a: assert property (disable iff (rst) goto_run_s
    |=> ##1 prog_addr[10:0] == $past(prog_data[10:0], 2)) else $error("bad jump");
  branch_squash_a: assert property (disable iff (rst) goto_run_s
    |=> ##2 $stable(w_out) && !data_we) else $error("slot not squashed");

  // ============================================================
  // Accumulator and arithmetic
  literal_load_a: assert property (disable iff (rst) $past(prog_data) == 14'h0000
    && prog_data[13:10] == 4'b1100 && !irq |=> ##1 w_out == $past(prog_data[7:0], 2))
    else $error("literal not loaded");
  literal_nowrite_a: assert property (disable iff (rst) $past(prog_data) == 14'h0000
    && prog_data[13:12] == 2'b11 && prog_data[13:10] != 4'b1101 |=> ##1 !data_we)
    else $error("literal op wrote file");
  add_carry_a: assert property (disable iff (rst) $past(prog_data, 2) == 14'h0000
    && $past(prog_data[13:10]) == 4'b1100 && prog_data[13:9] == 5'b11111 |=> ##1
    {status_out[0], w_out} == $past(prog_data[7:0], 2) + $past(prog_data[7:0], 3))
    else $error("sum or carry wrong");
  sub_borrow_a: assert property (disable iff (rst) $past(prog_data, 2) == 14'h0000
    && $past(prog_data[13:10]) == 4'b1100 && prog_data[13:9] == 5'b11110 |=> ##1
    status_out[0] == ($past(prog_data[7:0], 2) >= $past(prog_data[7:0], 3)))
    else $error("borrow wrong");

  cover property (goto_run_s);
  cover property (prog_addr == 12'hFFF);
  cover property (prog_data[13:9] == 5'b11110);
endmodule // exec_core_monitor

bind exec_core exec_core_monitor #(.STACK_DEPTH(STACK_DEPTH), .SP_W(SP_W)) u_mon (
  .clk(clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
  .data_raddr(data_raddr), .data_rdata(data_rdata), .data_waddr(data_waddr),
  .data_wdata(data_wdata), .data_we(data_we), .irq(irq), .w_out(w_out),
  .status_out(status_out));

// *** test/risc_core_alu_fetch_path_tb_top.sv ***
// Purpose: Self-checking bench for the execution core against a bench model.
// Assumes: irq rises only in the second program, after it has set GIE.
// Notes:   Runs through the top of program space to see the address wrap.
`timescale 1ns/1ps

module risc_core_alu_fetch_path_tb_top;
  localparam int NT = 20;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         irq = 1'b0;
  wire [11:0] prog_addr;
  wire [13:0] prog_data;
  wire [6:0]  data_raddr, data_waddr;
  wire [7:0]  data_rdata, data_wdata, w_out, status_out;
  wire        data_we;
  int         n_fail = 0;
  int         n_compared = 0;
  reg  [7:0]  rnd = 8'h28;
  logic [7:0] ew [$];
  logic [7:0] es [$];

  always #10 clk = ~clk;

  exec_core #(.STACK_DEPTH(8), .SP_W(3)) dut (.clk(clk), .rst(rst), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_raddr(data_raddr), .data_rdata(data_rdata),
    .data_waddr(data_waddr), .data_wdata(data_wdata), .data_we(data_we), .irq(irq),
    .w_out(w_out), .status_out(status_out));
  prog_file_model pm (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_raddr(data_raddr), .data_rdata(data_rdata), .data_waddr(data_waddr),
    .data_wdata(data_wdata), .data_we(data_we));

  function automatic [7:0] next_rnd(input [7:0] v);
    next_rnd = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    n_compared++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t ns: %s is %h, expected %h", $time, what, got, want);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ============================================================
  // Program build, model and checks
  initial begin
    int a, b, r, c, dc, t, g;
    logic [7:0]  st;
    logic [13:0] op;
    st = 8'h18;
    for (t = 0; t < 4096; t++) pm.rom[t] = 14'h0000;
    // Each triple is NOP, load a, then literal op with b
    for (t = 0; t < NT; t++) begin
      rnd = next_rnd(rnd);
      a = rnd;
      rnd = next_rnd(rnd);
      b = rnd;
      c = st[0];
      dc = st[1];
      case (t % 5)
        0: begin
          op = 14'h3E00;
          r = a + b;
          c = r > 255;
          dc = a % 16 + b % 16 > 15;
        end
        1: begin
          op = 14'h3C00;
          r = b - a;
          c = b >= a;
          dc = b % 16 >= a % 16;
        end
        2: begin
          op = 14'h3900;
          r = a & b;
        end
        3: begin
          op = 14'h3800;
          r = a | b;
        end
        default: begin
          op = 14'h3A00;
          r = a ^ b;
        end
      endcase
      st[0] = c[0];
      st[1] = dc[0];
      st[2] = (r & 255) == 0;
      pm.rom[3*t+1] = 14'h3000 | a[13:0];
      pm.rom[3*t+2] = op | b[13:0];
      ew.push_back(r[7:0]);
      es.push_back(st);
    end
    // Jump far up; the load behind it must never execute
    g = 3 * NT;
    pm.rom[g+1] = 14'h2FF0;
    pm.rom[g+2] = 14'h30FF;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    for (t = 0; t < NT; t++) begin
      repeat (t == 0 ? 4 : 3) @(posedge clk);
      #1;
      check(w_out, ew[t], "accumulator");
      check(status_out, es[t], "status");
      check(prog_addr, 16'(3 * t + 4), "fetch address");
    end
    repeat (2) @(posedge clk);
    #1;
    check(prog_addr, 16'h07F0, "jump address");
    repeat (2) @(posedge clk);
    #1;
    check(w_out, ew[NT-1], "accumulator after jump");
    repeat (2062) @(posedge clk);
    #1;
    check(prog_addr, 16'h0000, "wrapped address");
    // Second program from a fresh reset: file write, call, return and interrupt
    rst = 1'b1;
    for (t = 0; t < 4096; t++) pm.rom[t] = 14'h0000;
    rnd = next_rnd(rnd);
    a = rnd;
    rnd = next_rnd(rnd);
    b = rnd;
    r = a + b;
    st = 8'h18 | {5'b00000, (r & 255) == 0, a % 16 + b % 16 > 15, r > 255};
    // 0: jump to 8; 4: handler loads 77h and loops
    pm.rom[0]  = 14'h2808;
    pm.rom[4]  = 14'h3077;
    pm.rom[5]  = 14'h2805;
    // 8: load a, store at 20h, call 10h, add 20h into W, enable interrupts, loop
    pm.rom[8]  = 14'h3000 | a[13:0];
    pm.rom[9]  = 14'h00A0;
    pm.rom[10] = 14'h2010;
    pm.rom[11] = 14'h0720;
    pm.rom[12] = 14'h178B;
    pm.rom[13] = 14'h280D;
    // 10h: return with literal b
    pm.rom[16] = 14'h3400 | b[13:0];
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check(data_we, 16'h0001, "file write strobe");
    check(data_waddr, 16'h0020, "file write address");
    check(data_wdata, 16'(a), "file write data");
    @(posedge clk);
    #1;
    check(prog_addr, 16'h0010, "call target");
    check(data_we, 16'h0000, "file write strobe length");
    repeat (2) @(posedge clk);
    #1;
    check(w_out, 16'(b), "returned literal");
    check(prog_addr, 16'h000B, "return address");
    @(posedge clk);
    #1;
    check(data_raddr, 16'h0020, "file read address");
    @(posedge clk);
    #1;
    check(w_out, 16'(r & 255), "file add result");
    check(status_out, 16'(st), "file add flags");
    @(posedge clk);
    #1 irq = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(prog_addr, 16'h0004, "interrupt vector");
    repeat (2) @(posedge clk);
    #1;
    check(w_out, 16'h0077, "handler result");
    print_verdict();
  end

  // Expected run is about 2200 cycles
  initial begin
    #(20 * 5000);
    n_fail++;
    $display("unexpected at %0t ns: run did not finish", $time);
    print_verdict();
  end
endmodule // risc_core_alu_fetch_path_tb_top
